// *** include/xmd_pkg.sv ***
// Shared constants and types of the data-space map decoder
package xmd_pkg;
    // Whole decoded space and its regions
    localparam logic [15:0] SPACE_BASE   = 16'hF800; // Start of data buffers
    localparam logic [15:0] DATA_TOP     = 16'hFEEF; // Last data buffer byte
    localparam logic [15:0] EP0BUF_BASE  = 16'hFEF0; // Endpoint-0 buffers
    localparam logic [15:0] SETUP_BASE   = 16'hFF00; // Eight-byte setup packet
    localparam logic [15:0] EDB_BASE     = 16'hFF08; // Descriptor blocks
    localparam logic [15:0] EDB_RSV_BASE = 16'hFF40; // Reserved descriptor slot
    localparam logic [15:0] EDB_RSV_TOP  = 16'hFF47; // End of reserved slot
    localparam logic [15:0] MMR_BASE     = 16'hFF80; // Register window start
    // Register window layout
    localparam logic [15:0] FUNC_ADDR_ADDR = 16'hFFFF; // USB core, top
    localparam logic [15:0] USB_CTRL_ADDR  = 16'hFFFC; // USB core, bottom
    localparam logic [15:0] HUB_VIDH_ADDR  = 16'hFFFB; // Hub regs, top
    localparam logic [15:0] HUB_POTG_ADDR  = 16'hFFF5; // Hub regs, bottom
    localparam logic [15:0] EE_SLAVE_ADDR  = 16'hFFF3; // EEPROM port, top
    localparam logic [15:0] EE_STATUS_ADDR = 16'hFFF0; // EEPROM port, bottom
    localparam logic [15:0] DMA_BASE       = 16'hFFE0; // DMA pairs, bottom
    localparam logic [15:0] DMA_TOP        = 16'hFFE9; // DMA pairs, top
    localparam logic [15:0] UART1_BASE     = 16'hFFA0; // Serial port 1
    localparam logic [15:0] UART2_BASE     = 16'hFFB0; // Serial port 2
    localparam logic [15:0] UART_REGS      = 16'h000C; // Registers per port
    localparam logic [15:0] PP_TOP_ADDR    = 16'hFF9F; // Parallel port, top
    localparam logic [15:0] PP_LOW_ADDR    = 16'hFF99; // Parallel port, bottom
    localparam logic [15:0] MISC_BASE      = 16'hFF90; // Rom shadow and friends
    localparam logic [15:0] MISC_TOP       = 16'hFF94; // Out endpoint irq reg
    localparam logic [15:0] EP0R_BASE      = 16'hFF80; // Endpoint-0 regs
    localparam logic [15:0] EP0R_TOP       = 16'hFF83; // Endpoint-0 out count
    // Register indices the access check cares about
    localparam logic [3:0]  SER_TX_IDX = 4'h1; // Rx data 0, tx data 1
    localparam logic [3:0]  PP_DATA_IDX = 4'h1; // Parallel port data
    // Widths
    localparam int          BUF_AW = 11; // Byte address in the 2K space

    // Bus masters of the space
    typedef enum logic [1:0] {
        MS_MCU,
        MS_UBM,
        MS_DMA,
        MS_NONE
    } xmd_master_e;

    // Regions of the space
    typedef enum logic [2:0] {
        RG_OUTSIDE,
        RG_DATA,
        RG_EP0BUF,
        RG_SETUP,
        RG_EDB,
        RG_EDB_RSV,
        RG_MMR
    } xmd_region_e;

    // Units behind the register window
    typedef enum logic [3:0] {
        UN_NONE,
        UN_USB,
        UN_HUB,
        UN_EEPROM,
        UN_DMA,
        UN_UART,
        UN_PPORT,
        UN_MISC,
        UN_EP0
    } xmd_unit_e;
endpackage

// *** include/xmd_dec_if.sv ***
// Decode results passed between the decoder's own modules
`timescale 1ns/1ps
interface xmd_dec_if;
    logic [15:0]          addr;       // Requested address
    xmd_pkg::xmd_master_e master;     // Requesting master
    logic                 edb_update; // Access is a descriptor update
    xmd_pkg::xmd_region_e region;     // Region of the address
    xmd_pkg::xmd_unit_e   unit;       // Owning register unit
    logic                 data_reg;   // Unit register is a data register
    logic                 allow;      // Access is permitted

    modport top (output addr, master, edb_update, unit, data_reg, input region, allow);
    modport region_dec (input addr, output region);
    modport checker_p (input master, edb_update, region, unit, data_reg, output allow);
endinterface

// *** logic/xmd_region_dec.sv ***
// Splits the top 2K of the data space into its regions
`timescale 1ns/1ps
module xmd_region_dec (
    xmd_dec_if.region_dec dif
);
    // Region classification, highest first
    always_comb begin
        if (dif.addr >= xmd_pkg::MMR_BASE) begin
            dif.region = xmd_pkg::RG_MMR;
        end else if (dif.addr >= xmd_pkg::EDB_RSV_BASE && dif.addr <= xmd_pkg::EDB_RSV_TOP) begin
            dif.region = xmd_pkg::RG_EDB_RSV;
        end else if (dif.addr >= xmd_pkg::EDB_BASE) begin
            dif.region = xmd_pkg::RG_EDB;
        end else if (dif.addr >= xmd_pkg::SETUP_BASE) begin
            dif.region = xmd_pkg::RG_SETUP;
        end else if (dif.addr >= xmd_pkg::EP0BUF_BASE) begin
            dif.region = xmd_pkg::RG_EP0BUF;
        end else if (dif.addr >= xmd_pkg::SPACE_BASE && dif.addr <= xmd_pkg::DATA_TOP) begin
            dif.region = xmd_pkg::RG_DATA;
        end else begin
            dif.region = xmd_pkg::RG_OUTSIDE; // Not ours
        end
    end
endmodule // xmd_region_dec

// *** logic/xmd_access_check.sv ***
// Per-master permission check for the 2K data space
`timescale 1ns/1ps
module xmd_access_check (
    xmd_dec_if.checker_p dif
);
    // Permission by region and master
    always_comb begin
        case (dif.region)
            xmd_pkg::RG_DATA, xmd_pkg::RG_EP0BUF: begin
                // Open to every master but MS_NONE
                dif.allow = (dif.master != xmd_pkg::MS_NONE);
            end
            xmd_pkg::RG_SETUP: begin
                // Never the DMA
                dif.allow = (dif.master == xmd_pkg::MS_MCU) || (dif.master == xmd_pkg::MS_UBM);
            end
            xmd_pkg::RG_EDB: begin
                // Others only while updating a descriptor
                dif.allow = (dif.master == xmd_pkg::MS_MCU) ||
                            (dif.edb_update && (dif.master == xmd_pkg::MS_UBM ||
                                                dif.master == xmd_pkg::MS_DMA));
            end
            xmd_pkg::RG_MMR: begin
                if (dif.unit == xmd_pkg::UN_NONE) begin
                    dif.allow = 1'b0;
                end else if (dif.master == xmd_pkg::MS_MCU) begin
                    dif.allow = 1'b1;
                end else if (dif.master == xmd_pkg::MS_UBM) begin
                    dif.allow = (dif.unit == xmd_pkg::UN_EP0);
                end else if (dif.master == xmd_pkg::MS_DMA) begin
                    dif.allow = (dif.unit == xmd_pkg::UN_EP0) || dif.data_reg;
                end else begin
                    dif.allow = 1'b0; // Unknown master
                end
            end
            default: begin
                dif.allow = 1'b0;
            end
        endcase
    end
endmodule // xmd_access_check

// *** logic/xmd_top.sv ***
// Address decoder and access checker for the top 2K of the data space
`timescale 1ns/1ps
module xmd_top (
    input  wire logic                  core_clk,       // Data-bus clock
    input  wire logic                  rst_n,          // Device reset, async
    input  wire logic                  req_valid,      // Access request
    input  wire logic [1:0]            req_master,     // Requesting master
    input  wire logic [15:0]           req_addr,       // Byte address
    input  wire logic                  req_write,      // Write when high
    input  wire logic                  req_edb_update, // Descriptor update
    input  wire logic [7:0]            req_wdata,      // Write data
    output logic                       req_ready,      // Request accepted
    output logic                       ram_re,         // Buffer RAM read
    output logic                       ram_we,         // Buffer RAM write
    output logic [xmd_pkg::BUF_AW-1:0] ram_addr,       // Buffer RAM address
    input  wire logic [7:0]            ram_rdata,      // Buffer RAM data
    output logic                       reg_re,         // Register read
    output logic                       reg_we,         // Register write
    output xmd_pkg::xmd_unit_e         reg_unit,       // Owning unit
    output logic [2:0]                 reg_inst,       // Channel or port
    output logic [3:0]                 reg_index,      // Register in unit
    input  wire logic [7:0]            reg_rdata,      // Unit read data
    output logic [7:0]                 out_wdata,      // Write data out
    output logic                       rsp_valid,      // Access answered
    output logic                       rsp_blocked,    // Access refused
    output logic [7:0]                 rsp_data,       // Read data
    output logic                       viol_pulse,     // Refused access seen
    output logic [15:0]                viol_addr,      // Last refused address
    output logic [1:0]                 viol_master     // Last refused master
);

    // Registered state of the decoder
    typedef struct packed {
        logic                  ram_re;      // RAM read strobe
        logic                  ram_we;      // RAM write strobe
        logic                  reg_re;      // Register read strobe
        logic                  reg_we;      // Register write strobe
        logic [xmd_pkg::BUF_AW-1:0] ram_addr; // RAM address
        xmd_pkg::xmd_unit_e    unit;        // Unit select
        logic [2:0]            inst;        // Unit instance
        logic [3:0]            index;       // Register index
        logic [7:0]            wdata;       // Write data
        logic                  blk_pend;    // Refused access awaiting answer
        logic                  rsp_valid;   // Answer strobe
        logic                  rsp_blocked; // Answer is a refusal
        logic [7:0]            rsp_data;    // Answer data
        logic                  viol_pulse;  // Refusal strobe
        logic [15:0]           viol_addr;   // Refused address
        logic [1:0]            viol_master; // Refused master
    } xmd_state_s;

    xmd_state_s st;      // Current state
    xmd_state_s next_st; // Next state

    logic [1:0] rst_pipe;   // Reset release synchroniser
    logic       rst_core_n; // Synchronised reset

    // Decoded unit fields
    xmd_pkg::xmd_unit_e dec_unit;  // Unit behind the address
    logic [2:0]         dec_inst;  // Instance in the unit
    logic [3:0]         dec_index; // Register in the unit
    logic               dec_data;  // Data register flag
    logic               taken;     // Request claimed this cycle

    // Shared decode results
    xmd_dec_if dif ();

    // Region classification
    xmd_region_dec u_region (
        .dif (dif.region_dec)
    );

    // Permission check
    xmd_access_check u_check (
        .dif (dif.checker_p)
    );

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_core_n = rst_pipe[1];

    // Feed the request into the shared decode
    assign dif.addr       = req_addr;
    assign dif.master     = xmd_pkg::xmd_master_e'(req_master);
    assign dif.edb_update = req_edb_update;
    assign dif.unit       = dec_unit;
    assign dif.data_reg   = dec_data;

    // Register window: unit, instance and index
    always_comb begin
        logic [15:0] off;
        off       = 16'h0000;
        dec_unit  = xmd_pkg::UN_NONE;
        dec_inst  = 3'h0;
        dec_index = 4'h0;
        dec_data  = 1'b0;
        if (dif.region == xmd_pkg::RG_MMR) begin
            if (req_addr >= xmd_pkg::USB_CTRL_ADDR) begin
                // Func address, status, irq mask, control
                off       = xmd_pkg::FUNC_ADDR_ADDR - req_addr;
                dec_unit  = xmd_pkg::UN_USB;
                dec_index = off[3:0];
            end else if (req_addr >= xmd_pkg::HUB_POTG_ADDR && req_addr <= xmd_pkg::HUB_VIDH_ADDR) begin
                // Vid hi/lo, pid hi/lo, config 1/2, power good
                off       = xmd_pkg::HUB_VIDH_ADDR - req_addr;
                dec_unit  = xmd_pkg::UN_HUB;
                dec_index = off[3:0];
            end else if (req_addr >= xmd_pkg::EE_STATUS_ADDR && req_addr <= xmd_pkg::EE_SLAVE_ADDR) begin
                // Slave address, rx data, tx data, status
                off       = xmd_pkg::EE_SLAVE_ADDR - req_addr;
                dec_unit  = xmd_pkg::UN_EEPROM;
                dec_index = off[3:0];
            end else if (req_addr >= xmd_pkg::DMA_BASE && req_addr <= xmd_pkg::DMA_TOP) begin
                // Channel from the pair, even is definition
                off       = req_addr - xmd_pkg::DMA_BASE;
                dec_unit  = xmd_pkg::UN_DMA;
                dec_inst  = off[3:1];
                dec_index = {3'h0, off[0]};
            end else if (req_addr >= xmd_pkg::UART2_BASE &&
                         req_addr < xmd_pkg::UART2_BASE + xmd_pkg::UART_REGS) begin
                // Second serial port
                off       = req_addr - xmd_pkg::UART2_BASE;
                dec_unit  = xmd_pkg::UN_UART;
                dec_inst  = 3'h1;
                dec_index = off[3:0];
                dec_data  = (off[3:0] <= xmd_pkg::SER_TX_IDX);
            end else if (req_addr >= xmd_pkg::UART1_BASE &&
                         req_addr < xmd_pkg::UART1_BASE + xmd_pkg::UART_REGS) begin
                // First serial port
                off       = req_addr - xmd_pkg::UART1_BASE;
                dec_unit  = xmd_pkg::UN_UART;
                dec_index = off[3:0];
                dec_data  = (off[3:0] <= xmd_pkg::SER_TX_IDX);
            end else if (req_addr >= xmd_pkg::PP_LOW_ADDR && req_addr <= xmd_pkg::PP_TOP_ADDR) begin
                // Address, data, control, status, mask, mode, counter
                off       = xmd_pkg::PP_TOP_ADDR - req_addr;
                dec_unit  = xmd_pkg::UN_PPORT;
                dec_index = off[3:0];
                dec_data  = (off[3:0] == xmd_pkg::PP_DATA_IDX);
            end else if (req_addr >= xmd_pkg::MISC_BASE && req_addr <= xmd_pkg::MISC_TOP) begin
                // Rom shadow, global, vector, in irq, out irq
                off       = req_addr - xmd_pkg::MISC_BASE;
                dec_unit  = xmd_pkg::UN_MISC;
                dec_index = off[3:0];
            end else if (req_addr >= xmd_pkg::EP0R_BASE && req_addr <= xmd_pkg::EP0R_TOP) begin
                // In config, in count, out config, out count
                off       = req_addr - xmd_pkg::EP0R_BASE;
                dec_unit  = xmd_pkg::UN_EP0;
                dec_index = off[3:0];
            end else begin
                dec_unit  = xmd_pkg::UN_NONE;
            end
        end
    end

    // Ready as soon as the synchronised reset is released
    assign req_ready = rst_core_n;

    // Only addresses inside the 2K space are claimed
    assign taken = req_valid && req_ready && (dif.region != xmd_pkg::RG_OUTSIDE);

    // Next state: answer stage, then strobe stage
    always_comb begin
        next_st             = st;
        next_st.ram_re      = 1'b0;
        next_st.ram_we      = 1'b0;
        next_st.reg_re      = 1'b0;
        next_st.reg_we      = 1'b0;
        next_st.blk_pend    = 1'b0;
        next_st.rsp_valid   = 1'b0;
        next_st.viol_pulse  = 1'b0;
        // Answer one cycle after the strobe
        if (st.ram_re || st.ram_we || st.reg_re || st.reg_we || st.blk_pend) begin
            next_st.rsp_valid   = 1'b1;
            next_st.rsp_blocked = st.blk_pend;
            if (st.ram_re) begin
                next_st.rsp_data = ram_rdata;
            end else if (st.reg_re) begin
                next_st.rsp_data = reg_rdata;
            end else begin
                next_st.rsp_data = 8'h00;
            end
        end
        // Route or refuse the new request
        if (taken) begin
            if (dif.allow) begin
                next_st.wdata = req_wdata;
                if (dif.region == xmd_pkg::RG_MMR) begin
                    // Register unit access
                    next_st.reg_re = !req_write;
                    next_st.reg_we = req_write;
                    next_st.unit   = dec_unit;
                    next_st.inst   = dec_inst;
                    next_st.index  = dec_index;
                end else begin
                    // Buffer memory access
                    next_st.ram_re   = !req_write;
                    next_st.ram_we   = req_write;
                    next_st.ram_addr = req_addr[xmd_pkg::BUF_AW-1:0];
                end
            end else begin
                // No strobe, answer zero, record it
                next_st.blk_pend    = 1'b1;
                next_st.viol_pulse  = 1'b1;
                next_st.viol_addr   = req_addr;
                next_st.viol_master = req_master;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign ram_re      = st.ram_re;
    assign ram_we      = st.ram_we;
    assign ram_addr    = st.ram_addr;
    assign reg_re      = st.reg_re;
    assign reg_we      = st.reg_we;
    assign reg_unit    = st.unit;
    assign reg_inst    = st.inst;
    assign reg_index   = st.index;
    assign out_wdata   = st.wdata;
    assign rsp_valid   = st.rsp_valid;
    assign rsp_blocked = st.rsp_blocked;
    assign rsp_data    = st.rsp_data;
    assign viol_pulse  = st.viol_pulse;
    assign viol_addr   = st.viol_addr;
    assign viol_master = st.viol_master;

endmodule // xmd_top

// *** bench/xmd_top_properties.sv ***
// Port-level checker of the data-space map decoder
`timescale 1ns/1ps
module xmd_top_properties (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        req_valid,
    input wire logic [1:0]  req_master,
    input wire logic [15:0] req_addr,
    input wire logic        req_ready,
    input wire logic        ram_re,
    input wire logic        ram_we,
    input wire logic [10:0] ram_addr,
    input wire logic        reg_re,
    input wire logic [3:0]  reg_unit,
    input wire logic [2:0]  reg_inst,
    input wire logic [3:0]  reg_index,
    input wire logic        rsp_valid,
    input wire logic        rsp_blocked,
    input wire logic [7:0]  rsp_data,
    input wire logic        viol_pulse,
    input wire logic [15:0] viol_addr,
    input wire logic [1:0]  viol_master
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Request taken at this edge
    logic tk;
    assign tk = req_valid && req_ready;
    space_lower_a: assert property (tk && req_addr < 16'hF800 |=> !(ram_re || ram_we || reg_re || viol_pulse))
        else $error("request below the space was answered");
    window_no_ram_a: assert property (tk && req_addr >= 16'hFF80 |=> !(ram_re || ram_we))
        else $error("register window reached buffer RAM");
    buf_ram_a: assert property (tk && req_master == 2'h0 && req_addr >= 16'hF800 && req_addr < 16'hFF40
        |=> (ram_re || ram_we) && ram_addr == $past(req_addr[10:0]))
        else $error("buffer access not sent to RAM");
    setup_no_dma_a: assert property (tk && req_master == 2'h2 && req_addr[15:3] == 13'h1FE0
        |=> viol_pulse ##1 (rsp_valid && rsp_blocked))
        else $error("DMA reached the setup packet");
    usb_map_a: assert property (tk && req_master == 2'h0 && req_addr >= 16'hFFFC
        |=> reg_unit == xmd_pkg::UN_USB && reg_index == 4'hF - $past(req_addr[3:0]))
        else $error("USB core register misrouted");
    dma_pair_a: assert property (tk && req_master == 2'h0 && req_addr inside {[16'hFFE0:16'hFFE9]}
        |=> reg_unit == xmd_pkg::UN_DMA && reg_inst == $past(req_addr[3:1])
        && reg_index == {3'h0, $past(req_addr[0])})
        else $error("DMA channel register misrouted");
    pport_map_a: assert property (tk && req_master == 2'h0 && req_addr inside {[16'hFF99:16'hFF9F]}
        |=> reg_unit == xmd_pkg::UN_PPORT && reg_index == 4'hF - $past(req_addr[3:0]))
        else $error("parallel port register misrouted");
    ubm_window_a: assert property (tk && req_master == 2'h1 && req_addr >= 16'hFF84 |=> viol_pulse)
        else $error("buffer manager reached a register");
    blocked_zero_a: assert property (viol_pulse |=> rsp_valid && rsp_blocked && rsp_data == 8'h00)
        else $error("refused access answered wrongly");
    viol_record_a: assert property (tk && req_master == 2'h3 && req_addr >= 16'hF800
        |=> viol_pulse && viol_master == 2'h3 && viol_addr == $past(req_addr))
        else $error("refused access not recorded");
    // Main scenarios reached
    cover property (ram_we);
    cover property (reg_re ##1 rsp_valid);
    cover property (viol_pulse ##1 viol_pulse);
endmodule // xmd_top_properties

// *** bench/xmd_unit_model.sv ***
// Buffer RAM and register units standing behind the decoder
`timescale 1ns/1ps
module xmd_unit_model (
    input wire logic        core_clk,
    input wire logic        ram_re,
    input wire logic [10:0] ram_addr,
    input wire logic        reg_re,
    input wire logic [3:0]  reg_unit,
    input wire logic [2:0]  reg_inst,
    input wire logic [3:0]  reg_index,
    output logic [7:0]      ram_rdata,
    output logic [7:0]      reg_rdata
);
    // Pattern that changes every cycle while nothing is read
    logic [7:0] junk = 8'h00;
    always @(posedge core_clk) junk <= junk + 8'h3B;
    // Byte tied to the address, or to unit, register and channel
    always_comb begin
        ram_rdata = ram_re ? (ram_addr[7:0] ^ 8'hA5) : junk;
        reg_rdata = reg_re ? ({reg_unit, reg_index} ^ {5'h00, reg_inst}) : ~junk;
    end
endmodule // xmd_unit_model

// *** bench/external_data_space_io_map_decoder_test.sv ***
// Self-checking bench of the data-space map decoder
`timescale 1ns/1ps
module external_data_space_io_map_decoder_test;
    // Expected outcome of one request
    typedef struct packed {
        logic v, ok, ram, wr;
        xmd_pkg::xmd_unit_e un;
        logic [3:0] ix;
        logic [2:0] ch;
        logic [15:0] a;
        logic [1:0] m;
        logic [7:0] wd, rd;
    } xmd_exp_s;
    logic core_clk = 0, rst_n = 0, req_valid = 0, req_write = 0, req_edb_update = 0;
    logic [1:0] req_master = 0, viol_master;
    logic [15:0] req_addr = 0, viol_addr;
    logic [7:0] req_wdata = 0, ram_rdata, reg_rdata, out_wdata, rsp_data;
    logic req_ready, ram_re, ram_we, reg_re, reg_we, rsp_valid, rsp_blocked, viol_pulse;
    logic [xmd_pkg::BUF_AW-1:0] ram_addr;
    xmd_pkg::xmd_unit_e reg_unit;
    logic [2:0] reg_inst;
    logic [3:0] reg_index;
    int error_cnt = 0, tests_run = 0;
    logic [31:0] rnd = 32'hF374;
    xmd_exp_s s1 = '0, s2 = '0;
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Expected routing and permission of one access
    function automatic xmd_exp_s exp_of(logic [1:0] m, logic [15:0] a, logic w, logic e);
        xmd_exp_s x;
        logic win;
        x = '0;
        x.v = a >= 16'hF800;
        x.a = a;
        x.m = m;
        x.wr = w;
        x.ram = a < 16'hFF80;
        x.un = xmd_pkg::UN_NONE;
        if (!x.ram) begin
            if (a >= 16'hFFFC) begin x.un = xmd_pkg::UN_USB; x.ix = 4'hF - a[3:0]; end
            else if (a inside {[16'hFFF5:16'hFFFB]}) begin x.un = xmd_pkg::UN_HUB; x.ix = 4'hB - a[3:0]; end
            else if (a inside {[16'hFFF0:16'hFFF3]}) begin x.un = xmd_pkg::UN_EEPROM; x.ix = 4'h3 - a[3:0]; end
            else if (a inside {[16'hFFE0:16'hFFE9]}) begin
                x.un = xmd_pkg::UN_DMA; x.ix = {3'h0, a[0]}; x.ch = a[3:1];
            end
            else if (a[7:5] == 3'b101 && a[3:0] < 4'hC) begin
                x.un = xmd_pkg::UN_UART; x.ix = a[3:0]; x.ch = {2'h0, a[4]};
            end
            else if (a inside {[16'hFF99:16'hFF9F]}) begin x.un = xmd_pkg::UN_PPORT; x.ix = 4'hF - a[3:0]; end
            else if (a inside {[16'hFF90:16'hFF94]}) begin x.un = xmd_pkg::UN_MISC; x.ix = a[3:0]; end
            else if (a <= 16'hFF83) begin x.un = xmd_pkg::UN_EP0; x.ix = a[3:0]; end
        end
        win = (x.un == xmd_pkg::UN_UART && x.ix < 4'h2) || (x.un == xmd_pkg::UN_PPORT && x.ix == 4'h1);
        if (m == 2'h3 || !x.v) x.ok = 0;
        else if (a < 16'hFF00) x.ok = 1;
        else if (a < 16'hFF08) x.ok = m != 2'h2;
        else if (a < 16'hFF80) x.ok = !(a inside {[16'hFF40:16'hFF47]}) && (m == 2'h0 || e);
        else x.ok = x.un != xmd_pkg::UN_NONE && (m == 2'h0 || x.un == xmd_pkg::UN_EP0 || (m == 2'h2 && win));
        if (x.ok && !w)
            x.rd = x.ram ? a[7:0] ^ 8'hA5 : {x.un, x.ix} ^ {5'h00, x.ch};
        return x;
    endfunction
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One request, launched just after a rising edge
    task automatic send(logic v, logic [1:0] m, logic [15:0] a, logic w, logic e);
        @(posedge core_clk);
        #1;
        rnd = xs(rnd);
        req_valid = v;
        req_master = m;
        req_addr = a;
        req_write = w;
        req_edb_update = e;
        req_wdata = rnd[7:0];
    endtask
    initial forever #2 core_clk = ~core_clk;
    // Expectations move down the two-stage answer pipeline
    always @(posedge core_clk) begin
        s2 <= s1;
        s1 <= (req_valid === 1'b1 && req_ready === 1'b1) ? exp_of(req_master, req_addr, req_write, req_edb_update) : '0;
        s1.wd <= req_wdata;
    end
    // Outputs compared at mid-cycle, when settled
    always @(negedge core_clk) if (rst_n) begin
        check(ram_re, s1.ok & s1.ram & !s1.wr);
        check(ram_we, s1.ok & s1.ram & s1.wr);
        check(reg_re, s1.ok & !s1.ram & !s1.wr);
        check(reg_we, s1.ok & !s1.ram & s1.wr);
        check(viol_pulse, s1.v & !s1.ok);
        if (s1.ok & s1.ram) check(ram_addr, s1.a[10:0]);
        if (s1.ok & s1.wr) check(out_wdata, s1.wd);
        if (s1.ok & !s1.ram) check({reg_unit, reg_index}, {s1.un, s1.ix});
        if (s1.ok & !s1.ram) check(reg_inst, s1.ch);
        if (s1.v & !s1.ok) check({viol_master, viol_addr}, {s1.m, s1.a});
        check(rsp_valid, s2.v);
        if (s2.v) check({rsp_blocked, rsp_data}, {!s2.ok, s2.rd});
    end
    // Sweep of both boundaries with every master and kind, then random traffic
    initial begin
        int i;
        repeat (6) @(posedge core_clk);
        #1 rst_n = 1;
        for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(posedge core_clk);
        if (req_ready !== 1'b1) error_cnt++;
        else begin
            for (i = 0; i < 304 * 16; i++)
                send(1'b1, i[1:0], (i < 256) ? 16'hF7F8 + 16'(i / 16) : 16'hFEE0 + 16'(i / 16 - 16), i[2], i[3]);
            for (i = 0; i < 4000; i++) begin
                rnd = xs(rnd);
                send(rnd[20] | rnd[21], rnd[1:0], {5'h1F, rnd[12:2]} ^ {rnd[31], 15'h0000}, rnd[13], rnd[14]);
            end
            @(posedge core_clk);
            #1 req_valid = 0;
            repeat (4) @(posedge core_clk);
        end
        report_and_stop();
    end
    xmd_top dut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_master(req_master),
        .req_addr(req_addr), .req_write(req_write), .req_edb_update(req_edb_update), .req_wdata(req_wdata),
        .req_ready(req_ready), .ram_re(ram_re), .ram_we(ram_we), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
        .reg_re(reg_re), .reg_we(reg_we), .reg_unit(reg_unit), .reg_inst(reg_inst), .reg_index(reg_index),
        .reg_rdata(reg_rdata), .out_wdata(out_wdata), .rsp_valid(rsp_valid), .rsp_blocked(rsp_blocked),
        .rsp_data(rsp_data), .viol_pulse(viol_pulse), .viol_addr(viol_addr), .viol_master(viol_master));
    xmd_unit_model units (.core_clk(core_clk), .ram_re(ram_re), .ram_addr(ram_addr), .reg_re(reg_re),
        .reg_unit(reg_unit), .reg_inst(reg_inst), .reg_index(reg_index), .ram_rdata(ram_rdata),
        .reg_rdata(reg_rdata));
endmodule // external_data_space_io_map_decoder_test
bind xmd_top xmd_top_properties props (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_master(req_master), .req_addr(req_addr), .req_ready(req_ready), .ram_re(ram_re), .ram_we(ram_we),
    .ram_addr(ram_addr), .reg_re(reg_re), .reg_unit(reg_unit), .reg_inst(reg_inst), .reg_index(reg_index),
    .rsp_valid(rsp_valid), .rsp_blocked(rsp_blocked), .rsp_data(rsp_data), .viol_pulse(viol_pulse),
    .viol_addr(viol_addr), .viol_master(viol_master));
